// file: cell_convergence_block.sv
// Cell convergence block: cell framing between the ATM layer and a clear byte channel
// ==========================================
// Summary of operation
// - Buffers and idle cells decouple ATM-layer cell rate from line rate.
// - Transmit inserts idle cells; receive drops idle cells before the ATM layer.
// - Transmit inserts header check byte; receive checks and strips it.
// - Header check covers all four header bytes.
// - Any header check mismatch is uncorrectable; no single-bit correction.
// - Payload scrambled and descrambled with self-synchronising x^43+1 scrambler.
// - Receive locates cell boundaries by header check hunting.
// - Bits go MSB first, timed by the line clock from the lower sublayer.
// - Cells cross a byte-wide start-of-cell valid/ready cell interface.
// - Byte boundaries from the cell interface are kept in the line payload.
// - Cells travel in the clear channel one whole byte at a time.
// - Cell starts need not coincide with sub-block starts.
// - Each sub-block holds n 8-bit slots, each byte MSB first.
// - Slot one starts at the first bit of the sub-block, then in order.
// - Sub-block carries n contiguous bytes, no extra bits, 3 <= n < 36.
// - The same logic serves either end of the line.
// - Lower sublayer side is logical data lines with their clocks.
// - Cells move only after the valid/ready handshake completes.
`timescale 1ns/1ps
module cell_convergence_block (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic utx_valid,
  input wire logic utx_soc,
  input wire logic [7:0] utx_data,
  output logic utx_ready,
  output logic urx_valid,
  output logic urx_soc,
  output logic [7:0] urx_data,
  input wire logic urx_ready,
  input wire logic tx_line_clk,
  input wire logic tx_sblk_start,
  output logic tx_line_data,
  input wire logic rx_line_clk,
  input wire logic rx_line_data,
  output logic cell_sync,
  output logic hec_err,
  output logic rx_drop,
  output logic tx_underrun,
  output logic tx_slip
);
  fifo_if #(.W(cell_convergence_block_pkg::FIFO_W), .LW(cell_convergence_block_pkg::LVL_W)) tq ();
  fifo_if #(.W(cell_convergence_block_pkg::FIFO_W), .LW(cell_convergence_block_pkg::LVL_W)) rq ();

  cell_fifo #(.W(cell_convergence_block_pkg::FIFO_W), .DEPTH(cell_convergence_block_pkg::FIFO_DEPTH),
    .LW(cell_convergence_block_pkg::LVL_W)) u_tx_fifo (.clk(clk), .sys_rst(sys_rst), .q(tq.store));
  cell_fifo #(.W(cell_convergence_block_pkg::FIFO_W), .DEPTH(cell_convergence_block_pkg::FIFO_DEPTH),
    .LW(cell_convergence_block_pkg::LVL_W)) u_rx_fifo (.clk(clk), .sys_rst(sys_rst), .q(rq.store));

  // ==========================================
  // Line pin synchronisers
  logic tclk_s1, tclk_s2, tclk_s3, sblk_s1, sblk_s2;
  logic rclk_s1, rclk_s2, rclk_s3, rdat_s1, rdat_s2;
  logic tclk_rise, rclk_rise;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {tclk_s1, tclk_s2, tclk_s3, sblk_s1, sblk_s2} <= '0;
      {rclk_s1, rclk_s2, rclk_s3, rdat_s1, rdat_s2} <= '0;
    end else begin
      tclk_s1 <= tx_line_clk;
      tclk_s2 <= tclk_s1;
      tclk_s3 <= tclk_s2;
      sblk_s1 <= tx_sblk_start;
      sblk_s2 <= sblk_s1;
      rclk_s1 <= rx_line_clk;
      rclk_s2 <= rclk_s1;
      rclk_s3 <= rclk_s2;
      rdat_s1 <= rx_line_data;
      rdat_s2 <= rdat_s1;
    end
  end

  // Edges of the logical line clocks
  assign tclk_rise = tclk_s2 && !tclk_s3;
  assign rclk_rise = rclk_s2 && !rclk_s3;

  // ==========================================
  // Transmit side
  logic utx_ready_r, utx_ready_nxt;
  logic tx_bit_r, tx_bit_nxt;
  logic [7:0] tsh_r, tsh_nxt;
  logic [2:0] tbits_r, tbits_nxt;
  logic [5:0] pos_r, pos_nxt;
  logic [5:0] slot_r, slot_nxt;
  logic asg_r, asg_nxt, pay_r, pay_nxt;
  logic [31:0] hdr_r, hdr_nxt;
  logic [cell_convergence_block_pkg::SCR_LEN-1:0] scr_r, scr_nxt;
  logic underrun_r, underrun_nxt, slip_r, slip_nxt;
  logic [7:0] cur_byte, new_byte, idle_b;
  logic asg_now, pay_now, raw_bit, load;
  logic [cell_convergence_block_pkg::LVL_W:0] lvl_after;

  assign tq.push_valid = utx_valid && utx_ready_r;
  assign tq.push_data = {utx_soc, utx_data};

  always_comb begin
    tx_bit_nxt = tx_bit_r;
    tsh_nxt = tsh_r;
    tbits_nxt = tbits_r;
    pos_nxt = pos_r;
    slot_nxt = slot_r;
    asg_nxt = asg_r;
    pay_nxt = pay_r;
    hdr_nxt = hdr_r;
    scr_nxt = scr_r;
    underrun_nxt = 1'b0;
    slip_nxt = 1'b0;
    tq.pop_ready = 1'b0;
    new_byte = cell_convergence_block_pkg::IDLE_FILL;
    asg_now = asg_r;
    cur_byte = tsh_r;
    pay_now = pay_r;
    raw_bit = 1'b0;
    load = 1'b0;
    idle_b = 8'(cell_convergence_block_pkg::IDLE_HDR >> {2'd3 - pos_r[1:0], 3'b000});
    // Ready only while a further byte surely fits
    lvl_after = {1'b0, tq.level} + (cell_convergence_block_pkg::LVL_W + 1)'(tq.push_valid);
    utx_ready_nxt = lvl_after < (cell_convergence_block_pkg::LVL_W + 1)'(cell_convergence_block_pkg::FIFO_DEPTH);
    if (tclk_rise) begin
      // Sub-block start forces slot one to begin on this bit
      load = sblk_s2 || (tbits_r == 3'd0);
      if (load) begin
        if (pos_r == 6'd0) begin
          // No cell start at the head: idle cell instead
          asg_now = tq.pop_valid && tq.pop_data[cell_convergence_block_pkg::SOC_BIT];
          // Stray mid-cell byte at a boundary is flushed to regain alignment
          tq.pop_ready = tq.pop_valid && !asg_now;
        end
        if (pos_r == 6'(cell_convergence_block_pkg::HEC_POS)) begin
          // Header check byte follows the header
          new_byte = cell_convergence_block_pkg::hec_calc(hdr_r);
        end else if (asg_now) begin
          // Cell bytes pass whole, in order
          tq.pop_ready = 1'b1;
          if (tq.pop_valid) begin
            new_byte = tq.pop_data[7:0];
          end else begin
            new_byte = 8'h00;
            underrun_nxt = 1'b1;
          end
        end else if (pos_r < 6'(cell_convergence_block_pkg::HDR_BYTES)) begin
          new_byte = idle_b;
        end
        if (pos_r < 6'(cell_convergence_block_pkg::HDR_BYTES)) begin
          hdr_nxt = {hdr_r[23:0], new_byte};
        end
        pay_now = pos_r >= 6'(cell_convergence_block_pkg::PAY_START);
        pay_nxt = pay_now;
        asg_nxt = asg_now;
        cur_byte = new_byte;
        tbits_nxt = 3'd7;
        // Cell position runs free of the sub-block position
        pos_nxt = (pos_r == 6'(cell_convergence_block_pkg::CELL_BYTES - 1)) ? 6'd0 : pos_r + 6'd1;
        slip_nxt = sblk_s2 && ((slot_r != 6'd0) || (tbits_r != 3'd0));
        if (sblk_s2 || slot_r == 6'(cell_convergence_block_pkg::SLOTS_N - 1)) begin
          slot_nxt = sblk_s2 ? 6'd1 : 6'd0;
        end else begin
          slot_nxt = slot_r + 6'd1;
        end
      end else begin
        tbits_nxt = tbits_r - 3'd1;
      end
      raw_bit = cur_byte[7];
      tsh_nxt = {cur_byte[6:0], 1'b0};
      if (pay_now) begin
        tx_bit_nxt = raw_bit ^ scr_r[cell_convergence_block_pkg::SCR_LEN-1];
        scr_nxt = {scr_r[cell_convergence_block_pkg::SCR_LEN-2:0], tx_bit_nxt};
      end else begin
        tx_bit_nxt = raw_bit;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      utx_ready_r <= 1'b0;
      tx_bit_r <= 1'b0;
      tsh_r <= '0;
      tbits_r <= '0;
      pos_r <= '0;
      slot_r <= '0;
      asg_r <= 1'b0;
      pay_r <= 1'b0;
      hdr_r <= '0;
      scr_r <= '0;
      underrun_r <= 1'b0;
      slip_r <= 1'b0;
    end else begin
      utx_ready_r <= utx_ready_nxt;
      tx_bit_r <= tx_bit_nxt;
      tsh_r <= tsh_nxt;
      tbits_r <= tbits_nxt;
      pos_r <= pos_nxt;
      slot_r <= slot_nxt;
      asg_r <= asg_nxt;
      pay_r <= pay_nxt;
      hdr_r <= hdr_nxt;
      scr_r <= scr_nxt;
      underrun_r <= underrun_nxt;
      slip_r <= slip_nxt;
    end
  end

  // ==========================================
  // Receive side
  cell_convergence_block_pkg::delin_t st_r, st_nxt;
  logic [39:0] win_r, win_nxt;
  logic [2:0] rbits_r, rbits_nxt;
  logic [5:0] bytec_r, bytec_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [cell_convergence_block_pkg::SCR_LEN-1:0] dscr_r, dscr_nxt;
  logic [7:0] pb_r, pb_nxt;
  logic dlv_r, dlv_nxt;
  logic [31:0] hcap_r, hcap_nxt;
  logic [2:0] hcnt_r, hcnt_nxt;
  logic sync_r, sync_nxt, hec_err_r, hec_err_nxt, drop_r, drop_nxt;
  logic hec_ok, dbit;

  always_comb begin
    st_nxt = st_r;
    win_nxt = win_r;
    rbits_nxt = rbits_r;
    bytec_nxt = bytec_r;
    cnt_nxt = cnt_r;
    dscr_nxt = dscr_r;
    pb_nxt = pb_r;
    dlv_nxt = dlv_r;
    hcap_nxt = hcap_r;
    hcnt_nxt = hcnt_r;
    hec_err_nxt = 1'b0;
    drop_nxt = 1'b0;
    rq.push_valid = 1'b0;
    rq.push_data = '0;
    dbit = 1'b0;
    hec_ok = 1'b0;
    if (hcnt_r != 3'd0) begin
      // Header bytes replayed one per clock after the check passes
      rq.push_valid = 1'b1;
      rq.push_data = {hcnt_r == 3'd4, 8'(hcap_r >> {hcnt_r - 3'd1, 3'b000})};
      drop_nxt = !rq.push_ready;
      hcnt_nxt = hcnt_r - 3'd1;
    end
    if (rclk_rise) begin
      win_nxt = {win_r[38:0], rdat_s2};
      // Exact match only; a mismatch is never corrected
      hec_ok = cell_convergence_block_pkg::hec_calc(win_nxt[39:8]) == win_nxt[7:0];
      if (st_r == cell_convergence_block_pkg::ST_HUNT) begin
        // Bit-by-bit hunt for a valid header
        if (hec_ok) begin
          st_nxt = cell_convergence_block_pkg::ST_PRESYNC;
          bytec_nxt = 6'(cell_convergence_block_pkg::PAY_START);
          rbits_nxt = 3'd0;
          cnt_nxt = 3'd0;
          dlv_nxt = 1'b0;
        end
      end else begin
        if (bytec_r >= 6'(cell_convergence_block_pkg::PAY_START)) begin
          // Payload descrambled with the same polynomial
          dbit = rdat_s2 ^ dscr_r[cell_convergence_block_pkg::SCR_LEN-1];
          dscr_nxt = {dscr_r[cell_convergence_block_pkg::SCR_LEN-2:0], rdat_s2};
          pb_nxt = {pb_r[6:0], dbit};
        end
        rbits_nxt = rbits_r + 3'd1;
        if (rbits_r == 3'd7) begin
          // Whole bytes from the clear channel
          bytec_nxt = (bytec_r == 6'(cell_convergence_block_pkg::CELL_BYTES - 1)) ? 6'd0 : bytec_r + 6'd1;
          if (bytec_r >= 6'(cell_convergence_block_pkg::PAY_START) && dlv_r) begin
            rq.push_valid = 1'b1;
            rq.push_data = {1'b0, pb_nxt};
            drop_nxt = !rq.push_ready;
          end
          if (bytec_r == 6'(cell_convergence_block_pkg::HEC_POS)) begin
            // Confirm or lose delineation at each header
            dlv_nxt = 1'b0;
            if (!hec_ok) begin
              hec_err_nxt = 1'b1;
              if (st_r == cell_convergence_block_pkg::ST_PRESYNC) begin
                st_nxt = cell_convergence_block_pkg::ST_HUNT;
              end else if (cnt_r == 3'(cell_convergence_block_pkg::ALPHA - 1)) begin
                st_nxt = cell_convergence_block_pkg::ST_HUNT;
              end else begin
                cnt_nxt = cnt_r + 3'd1;
              end
            end else begin
              cnt_nxt = 3'd0;
              if (st_r == cell_convergence_block_pkg::ST_PRESYNC) begin
                if (cnt_r == 3'(cell_convergence_block_pkg::DELTA - 1)) begin
                  st_nxt = cell_convergence_block_pkg::ST_SYNC;
                end else begin
                  cnt_nxt = cnt_r + 3'd1;
                end
              end
              // Idle cells never reach the ATM layer
              // Only clean headers in sync are delivered
              if (st_nxt == cell_convergence_block_pkg::ST_SYNC && win_nxt[39:8] != cell_convergence_block_pkg::IDLE_HDR) begin
                dlv_nxt = 1'b1;
                // Check byte stripped: only four header bytes kept
                hcap_nxt = win_nxt[39:8];
                hcnt_nxt = 3'd4;
              end
            end
          end
        end
      end
    end
    sync_nxt = st_nxt == cell_convergence_block_pkg::ST_SYNC;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= cell_convergence_block_pkg::ST_HUNT;
      win_r <= '0;
      rbits_r <= '0;
      bytec_r <= '0;
      cnt_r <= '0;
      dscr_r <= '0;
      pb_r <= '0;
      dlv_r <= 1'b0;
      hcap_r <= '0;
      hcnt_r <= '0;
      sync_r <= 1'b0;
      hec_err_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      win_r <= win_nxt;
      rbits_r <= rbits_nxt;
      bytec_r <= bytec_nxt;
      cnt_r <= cnt_nxt;
      dscr_r <= dscr_nxt;
      pb_r <= pb_nxt;
      dlv_r <= dlv_nxt;
      hcap_r <= hcap_nxt;
      hcnt_r <= hcnt_nxt;
      sync_r <= sync_nxt;
      hec_err_r <= hec_err_nxt;
      drop_r <= drop_nxt;
    end
  end

  // ==========================================
  // Receive output register
  logic urx_valid_r, urx_valid_nxt, urx_soc_r, urx_soc_nxt;
  logic [7:0] urx_data_r, urx_data_nxt;

  always_comb begin
    // Next byte taken only once the current one is accepted
    rq.pop_ready = !urx_valid_r || urx_ready;
    urx_valid_nxt = urx_valid_r && !urx_ready;
    urx_soc_nxt = urx_soc_r;
    urx_data_nxt = urx_data_r;
    if (rq.pop_ready && rq.pop_valid) begin
      urx_valid_nxt = 1'b1;
      urx_soc_nxt = rq.pop_data[cell_convergence_block_pkg::SOC_BIT];
      urx_data_nxt = rq.pop_data[7:0];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      urx_valid_r <= 1'b0;
      urx_soc_r <= 1'b0;
      urx_data_r <= '0;
    end else begin
      urx_valid_r <= urx_valid_nxt;
      urx_soc_r <= urx_soc_nxt;
      urx_data_r <= urx_data_nxt;
    end
  end

  // ==========================================
  // Outputs
  // Byte-wide cell interface towards the ATM layer
  assign utx_ready = utx_ready_r;
  assign urx_valid = urx_valid_r;
  assign urx_soc = urx_soc_r;
  assign urx_data = urx_data_r;
  // Same pins serve either end; timing follows the line clock given
  assign tx_line_data = tx_bit_r;
  assign cell_sync = sync_r;
  assign hec_err = hec_err_r;
  assign rx_drop = drop_r;
  assign tx_underrun = underrun_r;
  assign tx_slip = slip_r;
endmodule

// file: cell_convergence_block_pkg.sv
// Constants, types and header check function for the cell convergence block
package cell_convergence_block_pkg;
  // ==========================================
  // Cell geometry
  localparam int CELL_BYTES = 53;
  localparam int HDR_BYTES = 4;
  localparam int HEC_POS = 4;
  localparam int PAY_START = 5;
  localparam int BYTE_W = 8;
  localparam int SOC_BIT = 8;
  // ==========================================
  // Payload sub-block: n 8-bit slots, 3 <= n < 36
  localparam int SLOTS_N = 12;
  // ==========================================
  // Buffering
  localparam int FIFO_W = 9;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;
  // ==========================================
  // Scrambler and delineation
  localparam int SCR_LEN = 43;
  localparam int DELTA = 6;
  localparam int ALPHA = 7;
  // ==========================================
  // Fixed codes
  localparam logic [31:0] IDLE_HDR = 32'h0000_0001;
  localparam logic [7:0] IDLE_FILL = 8'h6A;
  localparam logic [7:0] HEC_POLY = 8'h07;
  localparam logic [7:0] HEC_COSET = 8'h55;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_PRESYNC = 2'b01,
    ST_SYNC = 2'b10
  } delin_t;

  // CRC-8 over all four header bytes, coset added
  function automatic logic [7:0] hec_calc(input logic [31:0] hdr);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      if (crc[7] ^ hdr[i]) begin
        crc = {crc[6:0], 1'b0} ^ HEC_POLY;
      end else begin
        crc = {crc[6:0], 1'b0};
      end
    end
    return crc ^ HEC_COSET;
  endfunction
endpackage

// file: fifo_if.sv
// Valid/ready carrier between a byte source, a FIFO and its drain
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 9, parameter int LW = 5);
  logic push_valid;
  logic push_ready;
  logic [W-1:0] push_data;
  logic pop_valid;
  logic pop_ready;
  logic [W-1:0] pop_data;
  logic [LW-1:0] level;
  modport store (
    input push_valid, push_data, pop_ready,
    output push_ready, pop_valid, pop_data, level
  );
  modport user (
    output push_valid, push_data, pop_ready,
    input push_ready, pop_valid, pop_data, level
  );
endinterface

// file: cell_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module cell_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16,
  parameter int LW = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [LW-1:0] cnt_r, cnt_nxt;
  logic push, pop;

  // ==========================================
  // Handshake and pointers
  assign q.push_ready = (cnt_r != LW'(DEPTH));
  assign q.pop_valid = (cnt_r != '0);
  assign q.pop_data = mem[rd_r];
  assign q.level = cnt_r;
  assign push = q.push_valid && q.push_ready;
  assign pop = q.pop_ready && q.pop_valid;

  always_comb begin
    wr_nxt = push ? wr_r + 1'b1 : wr_r;
    rd_nxt = pop ? rd_r + 1'b1 : rd_r;
    cnt_nxt = cnt_r + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_r] <= q.push_data;
    end
  end
endmodule

// file: cell_convergence_block_sva.sv
// Port-level assertions for the cell convergence block
`timescale 1ns/1ps
module cell_convergence_block_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic utx_valid,
  input wire logic utx_soc,
  input wire logic [7:0] utx_data,
  input wire logic utx_ready,
  input wire logic urx_valid,
  input wire logic urx_soc,
  input wire logic [7:0] urx_data,
  input wire logic urx_ready,
  input wire logic tx_line_clk,
  input wire logic tx_sblk_start,
  input wire logic tx_line_data,
  input wire logic rx_line_clk,
  input wire logic rx_line_data,
  input wire logic cell_sync,
  input wire logic hec_err,
  input wire logic rx_drop,
  input wire logic tx_underrun,
  input wire logic tx_slip
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================
  // Helper counts
  // Bad headers since the last delivered cell start; idle cells are invisible here
  logic [7:0] since_soc_r, since_soc_nxt, bad_r, bad_nxt;
  always_comb begin
    since_soc_nxt = since_soc_r;
    bad_nxt = bad_r;
    if (urx_valid && urx_ready) begin
      since_soc_nxt = urx_soc ? 8'h01 : since_soc_r + 8'h01;
    end
    if (urx_valid && urx_ready && urx_soc) begin
      bad_nxt = 8'h00;
    end else if (hec_err && bad_r != 8'hFF) begin
      bad_nxt = bad_r + 8'h01;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_soc_r <= 8'h00;
      bad_r <= 8'h00;
    end else begin
      since_soc_r <= since_soc_nxt;
      bad_r <= bad_nxt;
    end
  end
  // ==========================================
  // Assertions
  a_reset_quiet: assert property (disable iff (1'b0)
    sys_rst |-> !utx_ready && !urx_valid && !cell_sync && !hec_err)
    else $error("output active in reset");
  a_ready_wake: assert property ($fell(sys_rst) |=> utx_ready)
    else $error("ready not up after reset");
  a_hec_pulse: assert property (hec_err |=> !hec_err)
    else $error("header error not a pulse");
  a_drop_cause: assert property (rx_drop |-> urx_valid || $past(urx_valid))
    else $error("drop with empty receive buffer");
  a_under_pulse: assert property (tx_underrun |=> !tx_underrun)
    else $error("underrun not a pulse");
  a_slip_pulse: assert property (tx_slip |=> !tx_slip)
    else $error("slip not a pulse");
  a_rx_hold: assert property (urx_valid && !urx_ready |=>
    urx_valid && $stable(urx_data) && $stable(urx_soc))
    else $error("receive byte changed before taken");
  a_hec_strip: assert property (urx_valid && urx_ready && !urx_soc |->
    since_soc_r inside {[8'h01:8'h33]})
    else $error("cell longer than 52 bytes");
  a_sync_loss: assert property ($fell(cell_sync) |->
    bad_r + 8'(hec_err) >= 8'(cell_convergence_block_pkg::ALPHA))
    else $error("sync lost too early");
  a_line_edge: assert property ($changed(tx_line_data) |->
    tx_line_clk || $past(tx_line_clk))
    else $error("line bit changed off link edge");
endmodule

// file: atm_layer_model.sv
// ATM layer stand-in: cell source and sink on the byte cell interface
`timescale 1ns/1ps
module atm_layer_model (
  input wire logic clk,
  input wire logic utx_ready,
  input wire logic urx_valid,
  input wire logic urx_soc,
  input wire logic [7:0] urx_data,
  output logic utx_valid,
  output logic utx_soc,
  output logic [7:0] utx_data,
  output logic urx_ready
);
  logic [8:0] rx_q[$];
  logic stall, slow, saw_full;
  initial begin
    utx_valid = 1'b0;
    utx_soc = 1'b0;
    utx_data = 8'h00;
    urx_ready = 1'b0;
    stall = 1'b0;
    slow = 1'b0;
    saw_full = 1'b0;
  end
  always @(negedge clk) begin
    urx_ready <= !stall && (!slow || !urx_ready);
    if (utx_valid && utx_ready === 1'b0) begin
      saw_full <= 1'b1;
    end
  end
  always @(posedge clk) begin
    if (urx_valid === 1'b1 && urx_ready === 1'b1) begin
      rx_q.push_back({urx_soc, urx_data});
    end
  end
  task automatic send_cell(input logic [7:0] seed, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      utx_valid = 1'b1;
      utx_soc = (i == 0);
      utx_data = seed + 8'(i);
      while (utx_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    utx_valid = 1'b0;
    utx_soc = 1'b0;
    utx_data = ~utx_data;
  endtask
endmodule

// file: tb_cell_convergence_block.sv
// Self-checking bench: line loopback through the cell convergence block
`timescale 1ns/1ps
module tb_cell_convergence_block;
  logic clk, sys_rst, lclk, sblk, err_r, rx_line_data;
  logic utx_valid, utx_soc, utx_ready, urx_valid, urx_soc, urx_ready;
  logic [7:0] utx_data, urx_data;
  logic tx_line_data, cell_sync, hec_err, rx_drop, tx_underrun, tx_slip;
  int mismatches, comparisons, n_hec, n_drop, n_under, n_slip, sc;
  // Line looped back; receive samples mid-bit on the inverted link clock
  assign rx_line_data = tx_line_data ^ err_r;
  cell_convergence_block i_dut (.clk(clk), .sys_rst(sys_rst), .utx_valid(utx_valid),
    .utx_soc(utx_soc), .utx_data(utx_data), .utx_ready(utx_ready), .urx_valid(urx_valid),
    .urx_soc(urx_soc), .urx_data(urx_data), .urx_ready(urx_ready), .tx_line_clk(lclk),
    .tx_sblk_start(sblk), .tx_line_data(tx_line_data), .rx_line_clk(~lclk),
    .rx_line_data(rx_line_data), .cell_sync(cell_sync), .hec_err(hec_err),
    .rx_drop(rx_drop), .tx_underrun(tx_underrun), .tx_slip(tx_slip));
  atm_layer_model i_atm (.clk(clk), .utx_ready(utx_ready), .urx_valid(urx_valid),
    .urx_soc(urx_soc), .urx_data(urx_data), .utx_valid(utx_valid), .utx_soc(utx_soc),
    .utx_data(utx_data), .urx_ready(urx_ready));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #20;
    forever #400 lclk = ~lclk;
  end
  always @(negedge lclk) begin
    sc = (sc == 95) ? 0 : sc + 1;
    sblk <= (sc == 0);
  end
  // Pulses counted mid-cycle, away from the edge that launches them
  always @(negedge clk) begin
    n_hec += (hec_err === 1'b1);
    n_drop += (rx_drop === 1'b1);
    n_under += (tx_underrun === 1'b1);
    if ($time > 2000000) n_slip += (tx_slip === 1'b1);
  end
  task automatic fail(input string m);
    mismatches++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) fail("flag");
  endtask
  task automatic check_byte(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) fail("byte");
  endtask
  task automatic check_cnt(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi) fail("count");
  endtask
  task automatic wait_q(input int n);
    for (int t = 0; t < 9000 && i_atm.rx_q.size() < n; t++) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_sync();
    for (int t = 0; t < 60000 && cell_sync !== 1'b1; t++) @(negedge clk);
    check_bit(cell_sync, 1'b1);
    check_cnt(i_atm.rx_q.size(), 0, 0);
  endtask
  task automatic t_cells();
    logic [7:0] s;
    i_atm.rx_q.delete();
    i_atm.slow = 1'b1;
    for (int c = 0; c < 3; c++) i_atm.send_cell(8'h10 + 8'(c * 48), 52);
    check_bit(i_atm.saw_full, 1'b1);
    wait_q(156);
    check_cnt(i_atm.rx_q.size(), 156, 156);
    for (int k = 0; k < 156; k++) begin
      s = 8'h10 + 8'((k / 52) * 48) + 8'(k % 52);
      check_byte(i_atm.rx_q[k], {1'(k % 52 == 0), s});
    end
    i_atm.slow = 1'b0;
  endtask
  // Cell cut short: padding keeps the line in whole bytes
  task automatic t_underrun();
    i_atm.rx_q.delete();
    n_under = 0;
    i_atm.send_cell(8'h20, 11);
    wait_q(52);
    check_cnt(n_under, 1, 41);
    check_cnt(i_atm.rx_q.size(), 52, 52);
    for (int k = 0; k < 11; k++) check_byte(i_atm.rx_q[k], {1'(k == 0), 8'h20 + 8'(k)});
  endtask
  task automatic t_stall();
    i_atm.rx_q.delete();
    i_atm.stall = 1'b1;
    n_drop = 0;
    i_atm.send_cell(8'h50, 52);
    repeat (3000) @(negedge clk);
    check_cnt(n_drop, 1, 52);
    i_atm.stall = 1'b0;
    wait_q(1);
    repeat (50) @(negedge clk);
    check_byte(i_atm.rx_q[0], 9'h150);
    check_cnt(i_atm.rx_q.size(), 1, 20);
  endtask
  task automatic t_errors();
    i_atm.rx_q.delete();
    n_hec = 0;
    err_r = 1'b1;
    repeat (3392) @(negedge clk);
    err_r = 1'b0;
    repeat (3400) @(negedge clk);
    check_cnt(n_hec, 1, 2);
    check_bit(cell_sync, 1'b1);
    check_cnt(i_atm.rx_q.size(), 0, 0);
    err_r = 1'b1;
    repeat (30528) @(negedge clk);
    check_bit(cell_sync, 1'b0);
    check_cnt(n_slip, 0, 0);
  endtask
  initial begin
    sys_rst = 1'b1;
    err_r = 1'b0;
    sblk = 1'b0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(posedge clk);
    t_sync();
    t_cells();
    t_underrun();
    t_stall();
    t_errors();
    end_sim();
  end
  initial begin
    // Scenarios need about 85k clocks; stay under the 96k budget
    #9600000;
    fail("timeout");
    end_sim();
  end
endmodule
bind cell_convergence_block cell_convergence_block_sva i_sva (.clk(clk), .sys_rst(sys_rst),
  .utx_valid(utx_valid), .utx_soc(utx_soc), .utx_data(utx_data), .utx_ready(utx_ready),
  .urx_valid(urx_valid), .urx_soc(urx_soc), .urx_data(urx_data), .urx_ready(urx_ready),
  .tx_line_clk(tx_line_clk), .tx_sblk_start(tx_sblk_start), .tx_line_data(tx_line_data),
  .rx_line_clk(rx_line_clk), .rx_line_data(rx_line_data), .cell_sync(cell_sync),
  .hec_err(hec_err), .rx_drop(rx_drop), .tx_underrun(tx_underrun), .tx_slip(tx_slip));
